// file: src/irq_pkg.sv
// Shared constants, encodings and bus carriers for the external and pin-change interrupt block.
package irq_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_EXT_IRQ    = 4;
  localparam int NUM_PC_GROUPS  = 4;
  localparam int PC_GROUP_W     = 8;
  localparam int PADDR_W        = 10;
  localparam int PDATA_W        = 32;
  localparam int REG_IDX_W      = 8;
  localparam int ADDR_LSB       = 2;
  localparam int BYTE_W         = 8;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [REG_IDX_W-1:0] IDX_PAD_REDIRECT = 8'h1A;
  localparam logic [REG_IDX_W-1:0] IDX_PC_FLAGS     = 8'h1B;
  localparam logic [REG_IDX_W-1:0] IDX_EXT_FLAGS    = 8'h1C;
  localparam logic [REG_IDX_W-1:0] IDX_EXT_ENABLE   = 8'h1D;
  localparam logic [REG_IDX_W-1:0] IDX_PC_GRP_EN    = 8'h68;
  localparam logic [REG_IDX_W-1:0] IDX_SENSE_CTRL   = 8'h69;
  localparam logic [REG_IDX_W-1:0] IDX_PC_MASK0     = 8'h6B;
  localparam logic [REG_IDX_W-1:0] IDX_PC_MASK1     = 8'h6C;
  localparam logic [REG_IDX_W-1:0] IDX_PC_MASK2     = 8'h6D;
  localparam logic [REG_IDX_W-1:0] IDX_GLOBAL_EN    = 8'h70;
  localparam logic [REG_IDX_W-1:0] IDX_PC_MASK3     = 8'h73;
  localparam logic [REG_IDX_W-1:0] IDX_EVT_STATUS   = 8'h74;
  localparam logic [REG_IDX_W-1:0] IDX_EVT_CLEAR    = 8'h75;
  localparam logic [REG_IDX_W-1:0] IDX_EVT_ENABLE   = 8'h76;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int              REDIR_SEL2_BIT = 2;
  localparam int              REDIR_SEL3_BIT = 3;
  localparam int              EXT_IRQ2       = 2;
  localparam int              EXT_IRQ3       = 3;
  localparam int              GIE_BIT        = 0;
  localparam int              EVT_PC_LSB     = 4;
  localparam logic [7:0]      RST_BYTE       = 8'h00;
  localparam logic [31:0]     RST_WORD       = 32'h0000_0000;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    SENSE_LOW  = 2'b00,
    SENSE_ANY  = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } sense_t;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b01,
    PH_ACCESS = 2'b10
  } apb_phase_t;

  // ****************************************************************
  // APB carriers
  // ****************************************************************
  typedef struct packed {
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [PADDR_W-1:0] paddr;
    logic [PDATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [PDATA_W-1:0] prdata;
    logic               pready;
    logic               pslverr;
  } apb_rsp_t;

endpackage

// file: src/ext_sense_detect.sv
// Sense detector for one external interrupt input: edge events and low-level state.
`timescale 1ns/100ps
`default_nettype none

module ext_sense_detect
  import irq_pkg::*;
(
  input  wire logic   mclk,
  input  wire logic   nrst,
  input  wire logic   level,
  input  wire sense_t sense,
  output logic        edge_hit,
  output logic        low_hit
);

  typedef struct packed {
    logic prev;
    logic primed;
  } det_state_t;

  det_state_t s_r;
  det_state_t s_nxt;
  logic       rise;
  logic       fall;

  // The primed bit keeps the first sample after reset from looking like an edge.
  always_comb begin
    s_nxt        = s_r;
    s_nxt.prev   = level;
    s_nxt.primed = 1'b1;
    rise         = s_r.primed & ~s_r.prev & level;
    fall         = s_r.primed & s_r.prev & ~level;
    case (sense)
      SENSE_ANY:  edge_hit = rise | fall;
      SENSE_FALL: edge_hit = fall;
      SENSE_RISE: edge_hit = rise;
      default:    edge_hit = 1'b0;
    endcase
    low_hit = (sense == SENSE_LOW) & ~level;
  end

  // State register.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // ext_sense_detect

`default_nettype wire

// file: src/pinchg_group_detect.sv
// Change detector for one group of pin-change inputs with per-pin mask.
`timescale 1ns/100ps
`default_nettype none

module pinchg_group_detect
  import irq_pkg::*;
#(
  parameter int WIDTH = PC_GROUP_W
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] pins,
  input  wire logic [WIDTH-1:0] mask,
  output logic                  change_hit
);

  typedef struct packed {
    logic [WIDTH-1:0] prev;
    logic             primed;
  } grp_state_t;

  grp_state_t s_r;
  grp_state_t s_nxt;

  // Any toggle on a pin whose mask bit is set counts; masked pins are ignored.
  always_comb begin
    s_nxt        = s_r;
    s_nxt.prev   = pins;
    s_nxt.primed = 1'b1;
    change_hit   = s_r.primed & (|((pins ^ s_r.prev) & mask));
  end

  // State register.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // pinchg_group_detect

`default_nettype wire

// file: src/ext_and_pin_change_irq.sv
// External and pin-change interrupt controller with APB register access.
`timescale 1ns/100ps
`default_nettype none

module ext_and_pin_change_irq
  import irq_pkg::*;
#(
  parameter int N_EXT    = NUM_EXT_IRQ,
  parameter int N_GROUPS = NUM_PC_GROUPS,
  parameter int GRP_W    = PC_GROUP_W
) (
  input  wire logic                      mclk,
  input  wire logic                      nrst,
  input  wire apb_req_t                  apb_req,
  output var  apb_rsp_t                  apb_rsp,
  input  wire logic [N_EXT-1:0]          ext_irq_input,
  input  wire logic                      alt_ext_irq2_pad,
  input  wire logic                      alt_ext_irq3_pad,
  input  wire logic [N_GROUPS*GRP_W-1:0] pinchg_input,
  input  wire logic                      sleep_active,
  input  wire logic [N_EXT-1:0]          ext_irq_ack,
  input  wire logic [N_GROUPS-1:0]       pinchg_ack,
  output logic [N_EXT-1:0]               ext_irq_req,
  output logic [N_GROUPS-1:0]            pinchg_req,
  output logic [N_EXT-1:0]               ext_pad_buffer_en,
  output logic                           irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    apb_phase_t                      phase;
    logic [PDATA_W-1:0]              prdata;
    logic                            pready;
    logic                            pslverr;
    logic [1:0]                      pad_sel;
    logic [N_EXT-1:0]                ext_flags;
    logic [N_EXT-1:0]                ext_en;
    logic [2*N_EXT-1:0]              sense;
    logic                            gie;
    logic [N_GROUPS-1:0]             pc_flags;
    logic [N_GROUPS-1:0]             pc_en;
    logic [N_GROUPS-1:0][GRP_W-1:0]  pc_mask;
    logic [N_EXT+N_GROUPS-1:0]       evt_status;
    logic [N_EXT+N_GROUPS-1:0]       evt_en;
    logic [N_EXT-1:0]                ext_req;
    logic [N_GROUPS-1:0]             pc_req;
    logic [N_EXT-1:0]                buf_en;
    logic                            irq;
  } irq_state_t;

  irq_state_t            s_r;
  irq_state_t            s_nxt;
  logic [N_EXT-1:0]      ext_level;
  logic [N_EXT-1:0]      ext_edge;
  logic [N_EXT-1:0]      ext_low;
  logic [N_GROUPS-1:0]   pc_change;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************

  // Word index of a byte address; the low two address bits select no register.
  function automatic logic [REG_IDX_W-1:0] reg_index(input logic [PADDR_W-1:0] addr);
    reg_index = addr[ADDR_LSB +: REG_IDX_W];
  endfunction

  // Mask register index for a given group number.
  function automatic logic [REG_IDX_W-1:0] mask_index(input int grp);
    case (grp)
      0:       mask_index = IDX_PC_MASK0;
      1:       mask_index = IDX_PC_MASK1;
      2:       mask_index = IDX_PC_MASK2;
      default: mask_index = IDX_PC_MASK3;
    endcase
  endfunction

  // True for every index that answers without an error.
  function automatic logic is_mapped(input logic [REG_IDX_W-1:0] idx);
    case (idx)
      IDX_PAD_REDIRECT, IDX_PC_FLAGS, IDX_EXT_FLAGS, IDX_EXT_ENABLE,
      IDX_PC_GRP_EN, IDX_SENSE_CTRL, IDX_PC_MASK0, IDX_PC_MASK1,
      IDX_PC_MASK2, IDX_GLOBAL_EN, IDX_PC_MASK3, IDX_EVT_STATUS,
      IDX_EVT_CLEAR, IDX_EVT_ENABLE: is_mapped = 1'b1;
      default:                       is_mapped = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // Pad selection and detectors
  // ****************************************************************

  // Redirected pads for inputs 2 and 3; a disabled buffer reads as low.
  always_comb begin
    ext_level = ext_irq_input;
    ext_level[EXT_IRQ2] = s_r.pad_sel[0] ? alt_ext_irq2_pad : ext_irq_input[EXT_IRQ2];
    ext_level[EXT_IRQ3] = s_r.pad_sel[1] ? alt_ext_irq3_pad : ext_irq_input[EXT_IRQ3];
    ext_level = ext_level & s_r.buf_en;
  end

  // One sense detector per external input.
  generate
    for (genvar n = 0; n < N_EXT; n++) begin : g_ext
      ext_sense_detect u_det (
        .mclk     (mclk),
        .nrst     (nrst),
        .level    (ext_level[n]),
        .sense    (sense_t'(s_r.sense[2*n +: 2])),
        .edge_hit (ext_edge[n]),
        .low_hit  (ext_low[n])
      );
    end
  endgenerate

  // One change detector per pin group; mclk is never gated here, so wake-up works in sleep.
  generate
    for (genvar g = 0; g < N_GROUPS; g++) begin : g_grp
      pinchg_group_detect #(
        .WIDTH (GRP_W)
      ) u_det (
        .mclk       (mclk),
        .nrst       (nrst),
        .pins       (pinchg_input[g*GRP_W +: GRP_W]),
        .mask       (s_r.pc_mask[g]),
        .change_hit (pc_change[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // Bus handling, flag updates and request generation in one place, so that every
  // clear and set of the same flag meet in a single expression.
  always_comb begin
    logic [REG_IDX_W-1:0]      idx;
    logic                      wr;
    logic [BYTE_W-1:0]         wd;
    logic [N_EXT-1:0]          level_mode;
    logic [N_EXT-1:0]          ext_set;
    logic [N_EXT-1:0]          ext_clr;
    logic [N_GROUPS-1:0]       pc_clr;
    logic [N_EXT+N_GROUPS-1:0] evt_set;
    logic [N_EXT+N_GROUPS-1:0] evt_clr;
    logic [BYTE_W-1:0]         rd;
    idx        = reg_index(apb_req.paddr);
    wr         = 1'b0;
    wd         = apb_req.pwdata[BYTE_W-1:0];
    level_mode = '0;
    evt_clr    = '0;
    ext_clr    = '0;
    pc_clr     = '0;
    ext_set    = '0;
    evt_set    = '0;
    rd         = RST_BYTE;
    s_nxt      = s_r;

    // APB phases: read data is captured in the setup cycle, write data in the access cycle, which completes at once.
    case (s_r.phase)
      PH_IDLE: begin
        if (apb_req.psel && !apb_req.penable) begin
          case (idx)
            IDX_PAD_REDIRECT: rd[REDIR_SEL3_BIT:REDIR_SEL2_BIT] = s_r.pad_sel;
            IDX_PC_FLAGS:     rd[N_GROUPS-1:0] = s_r.pc_flags;
            IDX_EXT_FLAGS:    rd[N_EXT-1:0] = s_r.ext_flags;
            IDX_EXT_ENABLE:   rd[N_EXT-1:0] = s_r.ext_en;
            IDX_PC_GRP_EN:    rd[N_GROUPS-1:0] = s_r.pc_en;
            IDX_SENSE_CTRL:   rd = s_r.sense;
            IDX_PC_MASK0:     rd = s_r.pc_mask[0];
            IDX_PC_MASK1:     rd = s_r.pc_mask[1];
            IDX_PC_MASK2:     rd = s_r.pc_mask[2];
            IDX_PC_MASK3:     rd = s_r.pc_mask[3];
            IDX_GLOBAL_EN:    rd[GIE_BIT] = s_r.gie;
            IDX_EVT_STATUS:   rd = s_r.evt_status;
            IDX_EVT_ENABLE:   rd = s_r.evt_en;
            default:          rd = RST_BYTE;
          endcase
          s_nxt.prdata  = apb_req.pwrite ? RST_WORD : {{(PDATA_W-BYTE_W){1'b0}}, rd};
          s_nxt.pslverr = ~is_mapped(idx);
          s_nxt.pready  = 1'b1;
          s_nxt.phase   = PH_ACCESS;
        end
      end
      PH_ACCESS: begin
        if (apb_req.psel && apb_req.penable) begin
          wr            = apb_req.pwrite & ~s_r.pslverr;
          s_nxt.pready  = 1'b0;
          s_nxt.pslverr = 1'b0;
          s_nxt.phase   = PH_IDLE;
        end
      end
      default: begin
        s_nxt.pready = 1'b0;
        s_nxt.phase  = PH_IDLE;
      end
    endcase

    // Register writes: control registers load, flag and clear registers clear the bits written as one; reserved bits are dropped on write.
    if (wr) begin
      case (idx)
        IDX_PAD_REDIRECT: s_nxt.pad_sel = wd[REDIR_SEL3_BIT:REDIR_SEL2_BIT];
        IDX_EXT_ENABLE:   s_nxt.ext_en = wd[N_EXT-1:0];
        IDX_PC_GRP_EN:    s_nxt.pc_en = wd[N_GROUPS-1:0];
        IDX_SENSE_CTRL:   s_nxt.sense = wd;
        IDX_GLOBAL_EN:    s_nxt.gie = wd[GIE_BIT];
        IDX_EXT_FLAGS:    ext_clr = wd[N_EXT-1:0];
        IDX_PC_FLAGS:     pc_clr = wd[N_GROUPS-1:0];
        IDX_EVT_CLEAR:    evt_clr = wd;
        IDX_EVT_ENABLE:   s_nxt.evt_en = wd;
        default:          s_nxt.gie = s_r.gie;
      endcase
      for (int g = 0; g < N_GROUPS; g++) begin
        if (idx == mask_index(g)) begin
          s_nxt.pc_mask[g] = wd;
        end
      end
    end

    // External flags: level mode never holds a flag, edges set it, set beats clear.
    for (int n = 0; n < N_EXT; n++) begin
      level_mode[n] = (sense_t'(s_r.sense[2*n +: 2]) == SENSE_LOW);
    end
    ext_set         = ext_edge & ~level_mode;
    ext_clr         = ext_clr | ext_irq_ack;
    s_nxt.ext_flags = ((s_r.ext_flags & ~ext_clr) | ext_set) & ~level_mode;

    // External requests: flag or live low level, gated by own and global enable.
    s_nxt.ext_req = (s_nxt.ext_flags | (level_mode & ext_low))
                    & s_nxt.ext_en & {N_EXT{s_nxt.gie}};

    // Sleep turns off the buffers of disabled external inputs.
    s_nxt.buf_en = ~({N_EXT{sleep_active}} & ~s_nxt.ext_en);

    // Group flags set on any unmasked change regardless of the group enable.
    pc_clr         = pc_clr | pinchg_ack;
    s_nxt.pc_flags = (s_r.pc_flags & ~pc_clr) | pc_change;
    s_nxt.pc_req   = s_nxt.pc_flags & s_nxt.pc_en & {N_GROUPS{s_nxt.gie}};

    // Sticky event status behind the summary interrupt line.
    evt_set          = {pc_change, ext_set | (level_mode & ext_low & s_r.ext_en)};
    s_nxt.evt_status = (s_r.evt_status & ~evt_clr) | evt_set;
    s_nxt.irq        = |(s_nxt.evt_status & s_nxt.evt_en);
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // All control state resets to zero; buffers come up enabled so pads are seen at once.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_r        <= '0;
      s_r.phase  <= PH_IDLE;
      s_r.buf_en <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Every output is a flip-flop of the state record.
  assign apb_rsp.prdata    = s_r.prdata;
  assign apb_rsp.pready    = s_r.pready;
  assign apb_rsp.pslverr   = s_r.pslverr;
  assign ext_irq_req       = s_r.ext_req;
  assign pinchg_req        = s_r.pc_req;
  assign ext_pad_buffer_en = s_r.buf_en;
  assign irq               = s_r.irq;

endmodule // ext_and_pin_change_irq

`default_nettype wire

// file: tb/irq_sva.sv
// Port-level assertions for the external and pin-change interrupt block.
`timescale 1ns/100ps
`default_nettype none

module irq_sva
  import irq_pkg::*;
#(
  parameter int N_EXT    = NUM_EXT_IRQ,
  parameter int N_GROUPS = NUM_PC_GROUPS,
  parameter int GRP_W    = PC_GROUP_W
) (
  input wire logic                      mclk,
  input wire logic                      nrst,
  input wire apb_req_t                  apb_req,
  input wire apb_rsp_t                  apb_rsp,
  input wire logic [N_EXT-1:0]          ext_irq_input,
  input wire logic [N_GROUPS*GRP_W-1:0] pinchg_input,
  input wire logic                      sleep_active,
  input wire logic [N_GROUPS-1:0]       pinchg_ack,
  input wire logic [N_EXT-1:0]          ext_irq_req,
  input wire logic [N_GROUPS-1:0]       pinchg_req,
  input wire logic [N_EXT-1:0]          ext_pad_buffer_en
);
  // ********************
  // Checks
  // ********************
  // A write access can raise a request by itself, so rises are excused near one.
  logic wr_acc;
  assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_ready_after_setup: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("pready missing after setup");
  a_ready_has_cause: assert property (apb_rsp.pready |-> $past(apb_req.psel && !apb_req.penable))
    else $error("pready without setup");
  a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  a_slverr_with_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr without pready");
  a_rdata_holds: assert property (!(apb_req.psel && !apb_req.penable) |=> $stable(apb_rsp.prdata))
    else $error("prdata moved without setup");
  a_buf_off_sleep: assert property (!(&ext_pad_buffer_en) |-> $past(sleep_active))
    else $error("pad buffer off while awake");
  a_pc_rise_cause: assert property ($rose(pinchg_req[0]) |-> wr_acc || $past(wr_acc)
    || $past(wr_acc, 2) || (pinchg_input[7:0] != $past(pinchg_input[7:0]))
    || ($past(pinchg_input[7:0]) != $past(pinchg_input[7:0], 2))
    || ($past(pinchg_input[7:0], 2) != $past(pinchg_input[7:0], 3)))
    else $error("group request rose without pin change");
  a_ext_rise_cause: assert property ($rose(ext_irq_req[0]) |-> wr_acc || $past(wr_acc)
    || $past(wr_acc, 2) || (ext_irq_input[0] != $past(ext_irq_input[0]))
    || ($past(ext_irq_input[0]) != $past(ext_irq_input[0], 2))
    || ($past(ext_irq_input[0], 2) != $past(ext_irq_input[0], 3)))
    else $error("external request rose without pad change");
  a_pc_ack_clear: assert property (pinchg_ack[0] && $stable(pinchg_input[7:0])
    && ($past(pinchg_input[7:0], 2) == pinchg_input[7:0]) |=> !pinchg_req[0])
    else $error("group request stayed after service entry");
endmodule // irq_sva

bind ext_and_pin_change_irq irq_sva #(.N_EXT(N_EXT), .N_GROUPS(N_GROUPS), .GRP_W(GRP_W))
  irq_sva_i (
  .mclk(mclk), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .ext_irq_input(ext_irq_input), .pinchg_input(pinchg_input), .sleep_active(sleep_active),
  .pinchg_ack(pinchg_ack), .ext_irq_req(ext_irq_req), .pinchg_req(pinchg_req),
  .ext_pad_buffer_en(ext_pad_buffer_en));

`default_nettype wire

// file: tb/pin_model.sv
// Model of the pads that feed the interrupt inputs.
`timescale 1ns/100ps
`default_nettype none

module pin_model (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [3:0]  want_ext,
  input  wire logic [1:0]  want_alt,
  input  wire logic [31:0] want_pc,
  output logic [3:0]       ext_pad,
  output logic [1:0]       alt_pad,
  output logic [31:0]      pc_pad
);
  // ********************
  // Pads
  // ********************
  // Pads settle one clock after a request, so every change lands on a rising mclk edge.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ext_pad <= 4'h0;
      alt_pad <= 2'h0;
      pc_pad  <= 32'h0;
    end else begin
      ext_pad <= want_ext;
      alt_pad <= want_alt;
      pc_pad  <= want_pc;
    end
  end
endmodule // pin_model

`default_nettype wire

// file: tb/tb.sv
// Self-checking testbench for the external and pin-change interrupt block.
`timescale 1ns/100ps
`default_nettype none

module tb;
  import irq_pkg::*;
  // ********************
  // Signals
  // ********************
  logic        mclk = 1'b0;
  logic        nrst;
  apb_req_t    req;
  apb_rsp_t    rsp;
  logic [3:0]  want_ext, ext_pad, ext_ack, ext_req, buf_en, nx, eo, ev, e, lo;
  logic [1:0]  want_alt, alt_pad, na;
  logic [31:0] want_pc, pc_pad, rd, m, t, rw;
  logic [3:0]  pc_ack, pc_req;
  logic [7:0]  s, r, ge;
  logic        sleep_active, irq, er, gi;
  int          errors, check_count, cyc;
  localparam logic [7:0] MIDX [4] = '{IDX_PC_MASK0, IDX_PC_MASK1, IDX_PC_MASK2, IDX_PC_MASK3};
  localparam logic [7:0] RIDX [8] = '{IDX_PAD_REDIRECT, IDX_PC_FLAGS, IDX_EXT_FLAGS,
    IDX_PC_GRP_EN, IDX_PC_MASK0, IDX_PC_MASK1, IDX_PC_MASK2, IDX_PC_MASK3};

  ext_and_pin_change_irq ext_and_pin_change_irq_i (
    .mclk(mclk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp), .ext_irq_input(ext_pad),
    .alt_ext_irq2_pad(alt_pad[0]), .alt_ext_irq3_pad(alt_pad[1]), .pinchg_input(pc_pad),
    .sleep_active(sleep_active), .ext_irq_ack(ext_ack), .pinchg_ack(pc_ack),
    .ext_irq_req(ext_req), .pinchg_req(pc_req), .ext_pad_buffer_en(buf_en), .irq(irq));
  pin_model pin_model_i (.mclk(mclk), .nrst(nrst), .want_ext(want_ext), .want_alt(want_alt),
    .want_pc(want_pc), .ext_pad(ext_pad), .alt_pad(alt_pad), .pc_pad(pc_pad));

  always #50 mclk = ~mclk;

  // A hang is cut short well past the roughly nine hundred cycles the run needs.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      errors++;
      end_sim();
    end
  end

  // ********************
  // Tasks and models
  // ********************
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Read data and error are taken at the very edge where pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx, 2'b00}, pwdata: d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do @(posedge mclk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string nm);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp, nm);
  endtask
  task automatic pins(input logic [31:0] pc, input logic [3:0] ex, input logic [1:0] al);
    want_pc <= pc;
    want_ext <= ex;
    want_alt <= al;
    wt(5);
  endtask
  function automatic logic [3:0] exp_pc(input logic [31:0] ch, input logic [31:0] mk);
    for (int g = 0; g < 4; g++) exp_pc[g] = |(ch[8*g+:8] & mk[8*g+:8]);
  endfunction
  function automatic logic [3:0] eff(input logic [3:0] p, input logic [1:0] a,
                                     input logic [7:0] rr);
    eff = p;
    if (rr[REDIR_SEL2_BIT]) eff[EXT_IRQ2] = a[0];
    if (rr[REDIR_SEL3_BIT]) eff[EXT_IRQ3] = a[1];
  endfunction
  function automatic logic [3:0] exp_ext(input logic [3:0] o, input logic [3:0] v,
                                         input logic [7:0] sc);
    for (int i = 0; i < 4; i++) begin
      case (sense_t'(sc[2*i+:2]))
        SENSE_RISE: exp_ext[i] = !o[i] && v[i];
        SENSE_FALL: exp_ext[i] = o[i] && !v[i];
        SENSE_ANY:  exp_ext[i] = o[i] != v[i];
        default:    exp_ext[i] = 1'b0;
      endcase
    end
  endfunction

  // ********************
  // Main sequence
  // ********************
  initial begin
    {nrst, sleep_active, gi} = 3'b000;
    {req, want_ext, want_alt, want_pc, ext_ack, pc_ack} = '0;
    {errors, check_count, cyc} = '0;
    void'($urandom(32'h2305));
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) rdchk(RIDX[i], 32'h0, "reset_value");
    apb(1'b0, 8'h00, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped_err");
    apb(1'b1, IDX_EXT_ENABLE, 32'hF);
    // Random masks, group enables and toggles; one pass runs with the global enable off.
    for (int k = 0; k < 16; k++) begin
      m = $urandom;
      t = (k == 0) ? 32'hFFFF_FFFF : $urandom;
      ge = 8'($urandom);
      gi = (k != 3);
      for (int g = 0; g < 4; g++) apb(1'b1, MIDX[g], {24'h0, m[8*g+:8]});
      rdchk(MIDX[k%4], {24'h0, m[8*(k%4)+:8]}, "mask");
      apb(1'b1, IDX_PC_GRP_EN, {24'h0, ge});
      rdchk(IDX_PC_GRP_EN, {24'h0, ge & 8'h0F}, "grp_en");
      apb(1'b1, IDX_GLOBAL_EN, {31'h0, gi});
      apb(1'b1, IDX_PC_FLAGS, 32'hF);
      pins(want_pc ^ t, want_ext, want_alt);
      rdchk(IDX_PC_FLAGS, {28'h0, exp_pc(t, m)}, "pc_flags");
      chk({28'h0, pc_req}, {28'h0, exp_pc(t, m) & ge[3:0] & {4{gi}}}, "pc_req");
    end
    // Service entry clears a group flag, except when a new change lands on the same edge.
    apb(1'b1, IDX_PC_MASK0, 32'hFF);
    apb(1'b1, IDX_PC_GRP_EN, 32'hF);
    apb(1'b1, IDX_PC_FLAGS, 32'hF);
    pins(want_pc ^ 32'h1, want_ext, want_alt);
    pc_ack <= 4'h1;
    @(posedge mclk) pc_ack <= 4'h0;
    wt(2);
    chk({31'h0, pc_req[0]}, 32'h0, "pc_ack_req");
    rdchk(IDX_PC_FLAGS, 32'h0, "pc_ack_flag");
    // The pad moves one edge after the request, so the acknowledge meets the change.
    want_pc <= want_pc ^ 32'h1;
    wt(1);
    pc_ack <= 4'h1;
    @(posedge mclk) pc_ack <= 4'h0;
    wt(2);
    rdchk(IDX_PC_FLAGS, 32'h1, "pc_set_wins");
    // Random sense codes, redirects and pads; the first pass sets all four codes.
    for (int k = 0; k < 12; k++) begin
      s = (k == 0) ? 8'h1B : 8'($urandom);
      rw = $urandom;
      r = rw[7:0] & 8'h0C;
      apb(1'b1, IDX_SENSE_CTRL, {24'h0, s});
      apb(1'b1, IDX_PAD_REDIRECT, rw);
      rdchk(IDX_PAD_REDIRECT, {24'h0, r}, "redirect");
      apb(1'b1, IDX_EXT_FLAGS, 32'hF);
      nx = 4'($urandom);
      na = 2'($urandom);
      eo = eff(want_ext, want_alt, r);
      ev = eff(nx, na, r);
      pins(want_pc, nx, na);
      e = exp_ext(eo, ev, s);
      for (int i = 0; i < 4; i++) lo[i] = (s[2*i+:2] == SENSE_LOW) && !ev[i];
      rdchk(IDX_EXT_FLAGS, {28'h0, e}, "ext_flags");
      chk({28'h0, ext_req}, {28'h0, e | lo}, "ext_req");
    end
    // Writing zero leaves an external flag alone; service entry clears it.
    apb(1'b1, IDX_SENSE_CTRL, 32'h55);
    apb(1'b1, IDX_EXT_FLAGS, 32'hF);
    pins(want_pc, want_ext ^ 4'h1, want_alt);
    apb(1'b1, IDX_EXT_FLAGS, 32'h0);
    rdchk(IDX_EXT_FLAGS, 32'h1, "ext_w0");
    ext_ack <= 4'h1;
    @(posedge mclk) ext_ack <= 4'h0;
    wt(2);
    chk({31'h0, ext_req[0]}, 32'h0, "ext_ack_req");
    // Interrupt line: raise, clear, then mask the group events.
    apb(1'b1, IDX_EVT_ENABLE, 32'hFF);
    apb(1'b1, IDX_EVT_CLEAR, 32'hFF);
    pins(want_pc ^ 32'h1, want_ext, want_alt);
    chk({31'h0, irq}, 32'h1, "irq_set");
    rdchk(IDX_EVT_STATUS, 32'h10, "evt_status");
    rdchk(IDX_EVT_CLEAR, 32'h0, "evt_clear_read");
    apb(1'b1, IDX_EVT_CLEAR, 32'hFF);
    wt(2);
    chk({31'h0, irq}, 32'h0, "irq_clear");
    apb(1'b1, IDX_EVT_ENABLE, 32'h0F);
    pins(want_pc ^ 32'h1, want_ext, want_alt);
    chk({31'h0, irq}, 32'h0, "irq_masked");
    rdchk(IDX_EVT_STATUS, 32'h10, "evt_sticky");
    // Sleep turns off only the buffers of disabled inputs.
    apb(1'b1, IDX_EXT_ENABLE, 32'h5);
    sleep_active <= 1'b1;
    wt(3);
    chk({28'h0, buf_en}, 32'h5, "buf_sleep");
    // A high pad on a disabled input falls when its buffer goes off; its enable keeps it quiet.
    chk({28'h0, ext_req}, 32'h0, "ext_req_off");
    rdchk(IDX_EXT_FLAGS, {28'h0, eff(want_ext, want_alt, r) & 4'hA}, "sleep_flags");
    sleep_active <= 1'b0;
    wt(3);
    chk({28'h0, buf_en}, 32'hF, "buf_awake");
    end_sim();
  end
endmodule // tb

`default_nettype wire
